// ---- logic/aif_dsp_pkg.sv ----
// Constants for the audio path control block: register indices, fields,
// reset values and filter constants. Assumes a 32-bit AHB-Lite register bus.
package aif_dsp_pkg;
  // Register indices; byte address is four times the index
  localparam logic [10:0] IDX_VOL_LEFT   = 11'h400;
  localparam logic [10:0] IDX_VOL_RIGHT  = 11'h401;
  localparam logic [10:0] IDX_FILTER     = 11'h410;
  localparam logic [10:0] IDX_ONE_GAINS1 = 11'h480;
  localparam logic [10:0] IDX_ONE_GAINS2 = 11'h481;
  localparam logic [10:0] IDX_ONE_COEF   = 11'h482;
  localparam logic [10:0] IDX_ONE_SPACE  = 11'h421;
  localparam logic [10:0] IDX_TWO_SPACE  = 11'h521;
  localparam logic [10:0] IDX_TWO_GAINS1 = 11'h580;
  localparam logic [10:0] IDX_TWO_GAINS2 = 11'h581;
  localparam logic [10:0] IDX_TWO_COEF   = 11'h582;
  localparam logic [10:0] IDX_MODE       = 11'h600;
  localparam int          COEF_WORDS     = 19;
  // Field positions
  localparam int B1_LSB = 11;
  localparam int B2_LSB = 6;
  localparam int B3_LSB = 1;
  localparam int EQ_ON_BIT = 0;
  localparam int LOW_TYPE_BIT = 0;
  localparam int DEPTH_LSB = 9;
  localparam int SPACE_ON_BIT = 8;
  localparam int COMMIT_BIT = 8;
  localparam int HPF_L_BIT = 12;
  localparam int HPF_R_BIT = 11;
  localparam int CORNER_LSB = 13;
  localparam int ULTRA_BIT = 0;
  localparam int COEF_MODE_BIT = 1;
  // Reset values and codes
  localparam logic [4:0] BAND_ZERO_DB = 5'h0c;
  localparam logic [4:0] BAND_MAX     = 5'h18;
  localparam logic [7:0] VOL_ZERO_DB  = 8'hc0;
  localparam logic [7:0] VOL_TOP      = 8'hef;
  localparam logic [7:0] VOL_MUTE     = 8'h00;
  localparam logic [8:0] VOL_UNITY    = 9'h0c0;
  localparam logic [15:0] GAINS1_RST  = 16'h6318;
  localparam logic [15:0] GAINS2_RST  = 16'h6300;
  // High-pass leak shifts per corner code
  localparam logic [3:0] HPF_SHIFT_HIFI = 4'hc;
  localparam logic [3:0] HPF_SHIFT_V1   = 4'h5;
  localparam logic [3:0] HPF_SHIFT_V2   = 4'h4;
  localparam logic [3:0] HPF_SHIFT_V3   = 4'h3;
  localparam int MANT_FRAC = 15;
  localparam int HTRANS_NONSEQ = 2;
endpackage

// ---- logic/aif_eq_3d_volume_hpf.sv ----
// Audio path control: equaliser and spatial settings for two playback
// ports, record volume with paired commit and DC high-pass for the record path.
// Assumes an AHB-Lite master, record samples synchronous to clock.
// Functional notes
// - Band gain 5-bit code, -12..+12 dB, 0Ch is 0 dB, above 18h reserved.
// - Band 1/2/3 at 15:11,10:6,5:1; bands 4/5 at 15:11,10:6; reset 0Ch.
// - Bit 0 of second gain register picks shelving or peak low band.
// - Coefficient mode reads band shapes from per-port coefficient registers.
// - Enable and band gains act identically in coefficient mode.
// - Spatial depth 5-bit at 13:9; zero means off.
// - Spatial effect applies only while bit 8 set; resets off per port.
// - Ultrasonic mode bypasses record volume and high-pass filter.
// - Volume code: 0 mutes, 0.375 dB steps about C0h, saturates above EFh.
// - Volume writes stay pending until commit bit written as one.
// - Commit bit 8 in both volume registers updates both; reads zero.
// - Volume 8-bit at 7:0, resets C0h.
// - Left and right high-pass each have an own enable.
// - Left enable bit 12, right bit 11, both reset off.
// - Corner field 14:13 picks hi-fi or three voice corners, resets 00.
// - Corner scales with sample rate; same coefficients at every rate.
// - Each port's equaliser runs on its own sample rate settings.
// - Equaliser applies only while bit 0 of first gain register set.
`timescale 1ns/100ps
module aif_eq_3d_volume_hpf
  import aif_dsp_pkg::*;
(
  input  wire logic               clock,        // 125 MHz clock
  input  wire logic               rst,          // Sync reset, high
  input  wire logic               ce,           // Clock enable
  input  wire logic               hsel,         // AHB select
  input  wire logic [31:0]        haddr,        // AHB address
  input  wire logic [1:0]         htrans,       // AHB transfer type
  input  wire logic               hwrite,       // AHB write
  input  wire logic [2:0]         hsize,        // AHB size
  input  wire logic [31:0]        hwdata,       // AHB write data
  input  wire logic               hready,       // AHB ready in
  output logic                    hreadyout,    // AHB ready out
  output logic [31:0]             hrdata,       // AHB read data
  output logic                    hresp,        // AHB response, OKAY
  input  wire logic signed [23:0] recLeftIn,    // Record left sample
  input  wire logic signed [23:0] recRightIn,   // Record right sample
  input  wire logic               recValid,     // Sample strobe
  output logic signed [23:0]      recLeftOut,   // Processed left
  output logic signed [23:0]      recRightOut,  // Processed right
  output logic                    recOutValid,  // Output strobe
  output logic [31:0]             portOneEq,    // Port one EQ settings
  output logic [31:0]             portTwoEq,    // Port two EQ settings
  output logic [5:0]              portOneSpace, // Port one spatial
  output logic [5:0]              portTwoSpace, // Port two spatial
  output logic                    portOneCoefOn,// Port one coefficient mode
  output logic                    portTwoCoefOn,// Port two coefficient mode
  input  wire logic               coefPort,     // Coefficient read port
  input  wire logic [4:0]         coefSel,      // Coefficient word index
  output logic [15:0]             coefData      // Coefficient word
);

  // 2^(f/16) in Q1.15
  function automatic logic [16:0] mant(input logic [3:0] f);
    unique case (f)
      4'h0: mant = 17'd32768;
      4'h1: mant = 17'd34219;
      4'h2: mant = 17'd35734;
      4'h3: mant = 17'd37316;
      4'h4: mant = 17'd38968;
      4'h5: mant = 17'd40693;
      4'h6: mant = 17'd42495;
      4'h7: mant = 17'd44376;
      4'h8: mant = 17'd46341;
      4'h9: mant = 17'd48393;
      4'ha: mant = 17'd50535;
      4'hb: mant = 17'd52773;
      4'hc: mant = 17'd55109;
      4'hd: mant = 17'd57549;
      4'he: mant = 17'd60097;
      4'hf: mant = 17'd62757;
    endcase
  endfunction

  // Gain of 0.375 dB per code step about unity, clamp and mute
  function automatic logic signed [23:0] vol_apply(
    input logic signed [23:0] x, input logic [7:0] code);
    logic [7:0] c;
    logic signed [8:0] e;
    logic signed [4:0] ex;
    logic signed [47:0] p;
    c = (code > VOL_TOP) ? VOL_TOP : code;
    e = $signed({1'b0, c}) - $signed(VOL_UNITY);
    ex = 5'(e >>> 4);
    p = 48'(x) * $signed({1'b0, mant(e[3:0])});
    p = p >>> MANT_FRAC;
    if (ex < 0)
      p = p >>> (-ex);
    else
      p = p <<< ex;
    if (code == VOL_MUTE)
      vol_apply = '0;
    else if (p > 48'sh7fffff)
      vol_apply = 24'sh7fffff;
    else if (p < -48'sh800000)
      vol_apply = -24'sh800000;
    else
      vol_apply = p[23:0];
  endfunction

  // Clamp reserved band codes to the top gain
  function automatic logic [4:0] band(input logic [15:0] r, input int lsb);
    band = (r[lsb +: 5] > BAND_MAX) ? BAND_MAX : r[lsb +: 5];
  endfunction

  function automatic logic [3:0] hpf_shift(input logic [1:0] cut);
    unique case (cut)
      2'b00: hpf_shift = HPF_SHIFT_HIFI;
      2'b01: hpf_shift = HPF_SHIFT_V1;
      2'b10: hpf_shift = HPF_SHIFT_V2;
      2'b11: hpf_shift = HPF_SHIFT_V3;
    endcase
  endfunction

  logic [15:0] oneGains1_reg, oneGains2_reg, twoGains1_reg, twoGains2_reg;
  logic [15:0] oneSpace_reg, twoSpace_reg, filter_reg, mode_reg;
  logic [7:0]  pendLeft_reg, pendRight_reg, actLeft_reg, actRight_reg;
  logic        commitReq_reg;
  logic [15:0] coefMem [2][COEF_WORDS];
  logic        wrPend_reg;
  logic [10:0] wrIdx_reg;
  logic        rdPend_reg;
  logic [10:0] rdIdx_reg;
  logic        accept;
  logic [15:0] wd;
  logic signed [24:0] xPrevL_reg, xPrevR_reg, yL_reg, yR_reg;
  logic signed [24:0] yL_next, yR_next;
  logic signed [23:0] hpL, hpR;
  logic [3:0]  sh;

  assign accept = hsel & hready & htrans[1];
  assign wd = hwdata[15:0];

  // Capture address phase; reads take one wait state so data is a flop
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      wrPend_reg <= 1'b0;
      rdPend_reg <= 1'b0;
      wrIdx_reg <= '0;
      rdIdx_reg <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else if (ce)
    begin
      wrPend_reg <= accept & hwrite;
      rdPend_reg <= accept & ~hwrite;
      if (accept)
      begin
        wrIdx_reg <= haddr[12:2];
        rdIdx_reg <= haddr[12:2];
      end
      hreadyout <= ~(accept & ~hwrite);
    end
  end

  // Read mux; unmapped reads return zero
  always_ff @(posedge clock)
  begin
    if (rst)
      hrdata <= '0;
    else if (ce && rdPend_reg)
    begin
      hrdata <= '0;
      if (rdIdx_reg == IDX_VOL_LEFT)
        hrdata[7:0] <= pendLeft_reg;
      else if (rdIdx_reg == IDX_VOL_RIGHT)
        hrdata[7:0] <= pendRight_reg;
      else if (rdIdx_reg == IDX_FILTER)
        hrdata[15:0] <= filter_reg;
      else if (rdIdx_reg == IDX_ONE_GAINS1)
        hrdata[15:0] <= oneGains1_reg;
      else if (rdIdx_reg == IDX_ONE_GAINS2)
        hrdata[15:0] <= oneGains2_reg;
      else if (rdIdx_reg == IDX_TWO_GAINS1)
        hrdata[15:0] <= twoGains1_reg;
      else if (rdIdx_reg == IDX_TWO_GAINS2)
        hrdata[15:0] <= twoGains2_reg;
      else if (rdIdx_reg == IDX_ONE_SPACE)
        hrdata[15:0] <= oneSpace_reg;
      else if (rdIdx_reg == IDX_TWO_SPACE)
        hrdata[15:0] <= twoSpace_reg;
      else if (rdIdx_reg == IDX_MODE)
        hrdata[15:0] <= mode_reg;
      else if (rdIdx_reg >= IDX_ONE_COEF &&
               rdIdx_reg < IDX_ONE_COEF + 11'(COEF_WORDS))
        hrdata[15:0] <= coefMem[0][5'(rdIdx_reg - IDX_ONE_COEF)];
      else if (rdIdx_reg >= IDX_TWO_COEF &&
               rdIdx_reg < IDX_TWO_COEF + 11'(COEF_WORDS))
        hrdata[15:0] <= coefMem[1][5'(rdIdx_reg - IDX_TWO_COEF)];
    end
  end

  // Control registers written in the data phase
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      oneGains1_reg <= GAINS1_RST;
      oneGains2_reg <= GAINS2_RST;
      twoGains1_reg <= GAINS1_RST;
      twoGains2_reg <= GAINS2_RST;
      oneSpace_reg <= '0;
      twoSpace_reg <= '0;
      filter_reg <= '0;
      mode_reg <= '0;
    end
    else if (ce && wrPend_reg)
    begin
      if (wrIdx_reg == IDX_ONE_GAINS1)
        oneGains1_reg <= wd;
      if (wrIdx_reg == IDX_ONE_GAINS2)
        oneGains2_reg <= {wd[15:6], 5'h00, wd[LOW_TYPE_BIT]};
      if (wrIdx_reg == IDX_TWO_GAINS1)
        twoGains1_reg <= wd;
      if (wrIdx_reg == IDX_TWO_GAINS2)
        twoGains2_reg <= {wd[15:6], 5'h00, wd[LOW_TYPE_BIT]};
      if (wrIdx_reg == IDX_ONE_SPACE)
        oneSpace_reg <= {2'b00, wd[13:8], 8'h00};
      if (wrIdx_reg == IDX_TWO_SPACE)
        twoSpace_reg <= {2'b00, wd[13:8], 8'h00};
      if (wrIdx_reg == IDX_FILTER)
        filter_reg <= {1'b0, wd[14:11], 11'h000};
      if (wrIdx_reg == IDX_MODE)
        mode_reg <= {14'h0000, wd[1:0]};
    end
  end

  // Coefficient words per port, no reset needed
  always_ff @(posedge clock)
  begin
    if (ce && wrPend_reg)
    begin
      if (wrIdx_reg >= IDX_ONE_COEF && wrIdx_reg < IDX_ONE_COEF + 11'(COEF_WORDS))
        coefMem[0][5'(wrIdx_reg - IDX_ONE_COEF)] <= wd;
      if (wrIdx_reg >= IDX_TWO_COEF && wrIdx_reg < IDX_TWO_COEF + 11'(COEF_WORDS))
        coefMem[1][5'(wrIdx_reg - IDX_TWO_COEF)] <= wd;
    end
  end

  // Coefficient read port toward the playback engine
  always_ff @(posedge clock)
  begin
    if (rst)
      coefData <= '0;
    else if (ce)
      coefData <= (coefSel < 5'(COEF_WORDS)) ? coefMem[coefPort][coefSel] : '0;
  end

  // Pending volumes and commit request; a new commit wins over the apply
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pendLeft_reg <= VOL_ZERO_DB;
      pendRight_reg <= VOL_ZERO_DB;
      commitReq_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (recValid)
        commitReq_reg <= 1'b0;
      if (wrPend_reg && (wrIdx_reg == IDX_VOL_LEFT || wrIdx_reg == IDX_VOL_RIGHT))
      begin
        if (wrIdx_reg == IDX_VOL_LEFT)
          pendLeft_reg <= wd[7:0];
        else
          pendRight_reg <= wd[7:0];
        if (wd[COMMIT_BIT])
          commitReq_reg <= 1'b1;
      end
    end
  end

  // Applied gains switch only on a sample strobe, both at once
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      actLeft_reg <= VOL_ZERO_DB;
      actRight_reg <= VOL_ZERO_DB;
    end
    else if (ce && recValid && commitReq_reg)
    begin
      actLeft_reg <= pendLeft_reg;
      actRight_reg <= pendRight_reg;
    end
  end

  // Leaky DC removal; leak is per sample so the corner tracks sample rate
  always_comb
  begin
    sh = hpf_shift(filter_reg[CORNER_LSB +: 2]);
    yL_next = 25'(recLeftIn) - xPrevL_reg + yL_reg - (yL_reg >>> sh);
    yR_next = 25'(recRightIn) - xPrevR_reg + yR_reg - (yR_reg >>> sh);
    hpL = filter_reg[HPF_L_BIT] ? yL_next[23:0] : recLeftIn;
    hpR = filter_reg[HPF_R_BIT] ? yR_next[23:0] : recRightIn;
  end

  // Filter history; cleared every cycle while off, so enabling starts clean
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      xPrevL_reg <= '0;
      xPrevR_reg <= '0;
      yL_reg <= '0;
      yR_reg <= '0;
    end
    else if (ce)
    begin
      if (!filter_reg[HPF_L_BIT] || recValid)
      begin
        xPrevL_reg <= filter_reg[HPF_L_BIT] ? 25'(recLeftIn) : '0;
        yL_reg <= filter_reg[HPF_L_BIT] ? yL_next : '0;
      end
      if (!filter_reg[HPF_R_BIT] || recValid)
      begin
        xPrevR_reg <= filter_reg[HPF_R_BIT] ? 25'(recRightIn) : '0;
        yR_reg <= filter_reg[HPF_R_BIT] ? yR_next : '0;
      end
    end
  end

  // Record output stage; ultrasonic mode passes samples untouched
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      recLeftOut <= '0;
      recRightOut <= '0;
      recOutValid <= 1'b0;
    end
    else if (ce)
    begin
      recOutValid <= recValid;
      if (recValid)
      begin
        if (mode_reg[ULTRA_BIT])
        begin
          recLeftOut <= recLeftIn;
          recRightOut <= recRightIn;
        end
        else
        begin
          recLeftOut <= vol_apply(hpL, commitReq_reg ? pendLeft_reg : actLeft_reg);
          recRightOut <= vol_apply(hpR, commitReq_reg ? pendRight_reg : actRight_reg);
        end
      end
    end
  end

  // Playback settings; each port's engine runs at its own rate
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      portOneEq <= '0;
      portTwoEq <= '0;
      portOneSpace <= '0;
      portTwoSpace <= '0;
      portOneCoefOn <= 1'b0;
      portTwoCoefOn <= 1'b0;
    end
    else if (ce)
    begin
      // Fields: on, lowtype, b5..b1
      portOneEq <= {5'h00, oneGains1_reg[EQ_ON_BIT], oneGains2_reg[LOW_TYPE_BIT],
                    band(oneGains2_reg, B2_LSB), band(oneGains2_reg, B1_LSB),
                    band(oneGains1_reg, B3_LSB), band(oneGains1_reg, B2_LSB),
                    band(oneGains1_reg, B1_LSB)};
      portTwoEq <= {5'h00, twoGains1_reg[EQ_ON_BIT], twoGains2_reg[LOW_TYPE_BIT],
                    band(twoGains2_reg, B2_LSB), band(twoGains2_reg, B1_LSB),
                    band(twoGains1_reg, B3_LSB), band(twoGains1_reg, B2_LSB),
                    band(twoGains1_reg, B1_LSB)};
      // Depth forced to zero (off) while disabled
      portOneSpace <= {oneSpace_reg[SPACE_ON_BIT],
                       oneSpace_reg[SPACE_ON_BIT] ? oneSpace_reg[DEPTH_LSB +: 5] : 5'h00};
      portTwoSpace <= {twoSpace_reg[SPACE_ON_BIT],
                       twoSpace_reg[SPACE_ON_BIT] ? twoSpace_reg[DEPTH_LSB +: 5] : 5'h00};
      portOneCoefOn <= mode_reg[COEF_MODE_BIT] & oneGains1_reg[EQ_ON_BIT];
      portTwoCoefOn <= mode_reg[COEF_MODE_BIT] & twoGains1_reg[EQ_ON_BIT];
    end
  end

endmodule

// ---- verification/aif_eq_3d_volume_hpf_sva.sv ----
// Port checker for the audio path control block.
// Assumes hready is fed from hreadyout and ce stays high.
`timescale 1ns/100ps
module aif_ctrl_chk
  import aif_dsp_pkg::*;
(
  input wire logic        clock,         // Clock
  input wire logic        rst,           // Sync reset
  input wire logic        ce,            // Clock enable
  input wire logic        hsel,          // Select
  input wire logic [1:0]  htrans,        // Transfer type
  input wire logic        hwrite,        // Write
  input wire logic        hready,        // Bus ready
  input wire logic        hreadyout,     // Slave ready
  input wire logic        hresp,         // Response
  input wire logic        recValid,      // Sample strobe
  input wire logic        recOutValid,   // Output strobe
  input wire logic [31:0] portOneEq,     // Port one EQ
  input wire logic [31:0] portTwoEq,     // Port two EQ
  input wire logic [5:0]  portOneSpace,  // Port one spatial
  input wire logic [5:0]  portTwoSpace,  // Port two spatial
  input wire logic        portOneCoefOn, // Port one coef mode
  input wire logic        portTwoCoefOn  // Port two coef mode
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  logic take;
  logic clampOk;
  // Accepted request, and every band field of both ports within range
  assign take = hsel && hready && htrans[1] && ce;
  always_comb
  begin
    clampOk = 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      if (portOneEq[i*5 +: 5] > BAND_MAX || portTwoEq[i*5 +: 5] > BAND_MAX)
      begin
        clampOk = 1'b0;
      end
    end
  end
  band_clamp_a: assert property (clampOk)
    else $error("band code above top step");
  eq_upper_a: assert property (portOneEq[31:27] == 5'h0 && portTwoEq[31:27] == 5'h0)
    else $error("unused eq bits set");
  depth_off_a: assert property (!portOneSpace[5] |-> portOneSpace[4:0] == 5'h0)
    else $error("port one depth while off");
  depth_two_a: assert property (!portTwoSpace[5] |-> portTwoSpace[4:0] == 5'h0)
    else $error("port two depth while off");
  coef_eq_a: assert property ((!portOneCoefOn || portOneEq[26]) && (!portTwoCoefOn || portTwoEq[26]))
    else $error("coef mode without eq on");
  sample_out_a: assert property (recValid && ce |=> recOutValid)
    else $error("sample not answered");
  no_spur_a: assert property (recOutValid |-> $past(recValid))
    else $error("output strobe without sample");
  read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  okay_resp_a: assert property (!hresp)
    else $error("response not okay");
  cover property (take && !hwrite);
  cover property (take && hwrite);
  cover property (recValid ##1 recOutValid);
endmodule

bind aif_eq_3d_volume_hpf aif_ctrl_chk i_chk (.*);

// ---- verification/record_source.sv ----
// Model of the record audio interface feeding sample pairs.
// Assumes the bench calls send once per sample period.
`timescale 1ns/100ps
module record_source
(
  input  wire logic          clock,      // Bench clock
  output logic signed [23:0] recLeftIn,  // Left sample
  output logic signed [23:0] recRightIn, // Right sample
  output logic               recValid    // Sample strobe
);
  initial
  begin
    recLeftIn = 24'h5a5a5a;
    recRightIn = 24'ha5a5a5;
    recValid = 1'b0;
  end
  // One strobe qualifies both channels; afterwards lines show the inverse so stale data fails
  task automatic send(input logic signed [23:0] l, input logic signed [23:0] r);
    @(posedge clock);
    recLeftIn <= l;
    recRightIn <= r;
    recValid <= 1'b1;
    @(posedge clock);
    recLeftIn <= ~l;
    recRightIn <= ~r;
    recValid <= 1'b0;
  endtask
endmodule

// ---- verification/tb_aif_eq_3d_volume_hpf.sv ----
// Self-checking bench for the audio path control block.
// Assumes one bus slave, so hready is the slave's own hreadyout.
`timescale 1ns/100ps
module tb_aif_eq_3d_volume_hpf
  import aif_dsp_pkg::*;
;
  // Inputs, changed only after rising edges
  logic               clock = 1'b0;
  logic               rst = 1'b1;
  logic               ce = 1'b1;
  logic               hsel = 1'b0;
  logic [31:0]        haddr = 32'h0;
  logic [1:0]         htrans = 2'h0;
  logic               hwrite = 1'b0;
  logic [2:0]         hsize = 3'h2;
  logic [31:0]        hwdata = 32'h0;
  logic               coefPort = 1'b0;
  logic [4:0]         coefSel = 5'h0;
  logic               hready, hreadyout, hresp, recValid, recOutValid;
  logic               portOneCoefOn, portTwoCoefOn;
  logic [31:0]        hrdata, portOneEq, portTwoEq;
  logic [5:0]         portOneSpace, portTwoSpace;
  logic [15:0]        coefData;
  logic signed [23:0] recLeftIn, recRightIn, recLeftOut, recRightOut;
  int                 failures = 0;
  int                 samplesChecked = 0;
  int                 cycles = 0;
  assign hready = hreadyout;
  aif_eq_3d_volume_hpf i_dut (.*);
  record_source i_src (.*);
  // Clock, and a hang guard far above the few hundred cycles needed
  always #4 clock = ~clock;
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", samplesChecked, failures);
    if (failures == 0 && samplesChecked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One single transfer; waits for ready in both phases, no fixed latency
  task automatic bus(input logic w, input logic [10:0] i, input logic [31:0] v,
                     output logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'(HTRANS_NONSEQ);
    haddr <= {19'h0, i, 2'b00};
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= v;
    do @(posedge clock); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask
  task automatic wr(input logic [10:0] i, input logic [31:0] v);
    logic [31:0] d;
    bus(1'b1, i, v, d);
  endtask
  task automatic rdchk(input logic [10:0] i, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] d;
    bus(1'b0, i, 32'h0, d);
    check(d & m, e & m);
  endtask
  task automatic rec(input logic signed [23:0] l, input logic signed [23:0] r,
                     input logic signed [23:0] el, input logic signed [23:0] er);
    i_src.send(l, r);
    #1;
    check(32'(recLeftOut), 32'(el));
    check(32'(recRightOut), 32'(er));
  endtask
  // Expected values worked out from field positions and code ranges
  function automatic logic [4:0] cl(input logic [4:0] g);
    return (g > BAND_MAX) ? BAND_MAX : g;
  endfunction
  function automatic logic [31:0] eqx(input logic [15:0] a, input logic [15:0] b);
    return {5'h0, a[EQ_ON_BIT], b[LOW_TYPE_BIT], cl(b[B2_LSB +: 5]), cl(b[B1_LSB +: 5]),
            cl(a[B3_LSB +: 5]), cl(a[B2_LSB +: 5]), cl(a[B1_LSB +: 5])};
  endfunction
  function automatic logic signed [23:0] hp(input logic signed [23:0] v, input int c);
    logic [3:0] k;
    k = (c == 0) ? HPF_SHIFT_HIFI : (c == 1) ? HPF_SHIFT_V1 : (c == 2) ? HPF_SHIFT_V2
      : HPF_SHIFT_V3;
    return v - (v >>> k);
  endfunction
  // Main sequence
  initial
  begin
    logic [31:0]        d;
    logic [15:0]        a, b;
    logic [10:0]        g;
    logic signed [23:0] x;
    void'($urandom(73402));
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    rdchk(IDX_TWO_GAINS1, 32'(GAINS1_RST), 32'hffff);
    rdchk(IDX_TWO_GAINS2, 32'(GAINS2_RST), 32'hffc1);
    rdchk(IDX_VOL_RIGHT, 32'h0c0, 32'h1ff);
    rdchk(IDX_FILTER, 32'h0, 32'h7800);
    rdchk(IDX_TWO_SPACE, 32'h0, 32'h3f00);
    rdchk(11'h7ff, 32'h0, 32'hffffffff);
    check(portTwoEq, eqx(GAINS1_RST, GAINS2_RST));
    $display("reset test done");
    for (int n = 0; n < 8; n++)
    begin
      a = 16'($urandom);
      b = 16'($urandom);
      a[B1_LSB +: 5] = (n < 2) ? 5'h19 - 5'(n) : a[B1_LSB +: 5];
      g = IDX_ONE_GAINS1 + (n[0] ? 11'h100 : 11'h0);
      wr(g, {16'h0, a});
      wr(g + 11'h1, {16'h0, b});
      rdchk(g, {16'h0, a}, 32'hffff);
      #1;
      check(n[0] ? portTwoEq : portOneEq, eqx(a, b));
      d = 32'($urandom) & 32'h3f00;
      wr(IDX_ONE_SPACE + (n[0] ? 11'h100 : 11'h0), d);
      @(posedge clock);
      #1;
      check(32'(n[0] ? portTwoSpace : portOneSpace),
            d[8] ? 32'(d[13:9]) | 32'h20 : 32'h0);
    end
    $display("playback settings test done");
    x = 24'($urandom_range(1, 20'hfffff));
    wr(IDX_VOL_LEFT, 32'h0);
    wr(IDX_VOL_RIGHT, 32'h0);
    rdchk(IDX_VOL_LEFT, 32'h0, 32'h1ff);
    rec(x, -x, x, -x);
    wr(IDX_VOL_RIGHT, 32'h100);
    rec(x, -x, 24'h0, 24'h0);
    rdchk(IDX_VOL_RIGHT, 32'h0, 32'h1ff);
    wr(IDX_VOL_RIGHT, 32'h0c0);
    wr(IDX_VOL_LEFT, 32'h1c0);
    rec(x, x, x, x);
    $display("volume test done");
    wr(IDX_FILTER, 32'h7800);
    wr(IDX_VOL_LEFT, 32'h100);
    wr(IDX_MODE, 32'h1);
    rec(x, x, x, x);
    rec(x, x, x, x);
    wr(IDX_MODE, 32'h0);
    wr(IDX_FILTER, 32'h0);
    wr(IDX_VOL_LEFT, 32'h1c0);
    $display("ultrasonic test done");
    for (int c = 0; c < 4; c++)
    begin
      wr(IDX_FILTER, (32'(c) << CORNER_LSB) | (32'h1 << HPF_L_BIT));
      rec(x, x, x, x);
      rec(x, x, hp(x, c), x);
      wr(IDX_FILTER, 32'h0);
    end
    $display("high-pass test done");
    wr(IDX_ONE_GAINS1, 32'h6319);
    wr(IDX_TWO_GAINS1, 32'h6318);
    wr(IDX_MODE, 32'h2);
    @(posedge clock);
    #1;
    check({30'h0, portOneCoefOn, portTwoCoefOn}, 32'h2);
    a = 16'($urandom);
    b = ~a;
    wr(IDX_ONE_COEF + 11'h3, {16'h0, a});
    wr(IDX_TWO_COEF + 11'h3, {16'h0, b});
    @(posedge clock);
    coefSel <= 5'h3;
    repeat (2) @(posedge clock);
    #1;
    check(32'(coefData), 32'(a));
    @(posedge clock);
    coefPort <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    check(32'(coefData), 32'(b));
    @(posedge clock);
    coefSel <= 5'(COEF_WORDS);
    repeat (2) @(posedge clock);
    #1;
    check(32'(coefData), 32'h0);
    $display("coefficient test done");
    tally_and_finish();
  end
endmodule
